// ### sw_master.sv
`timescale 1ns/10ps

// Functional notes
// RULE_01: Reset pulse holds the line low 511 us, never under 480 us, then releases.
// RULE_02: After the reset pulse the line stays released 512 us before any slot.
// RULE_03: Slave starts its presence pulse 15 to 60 us after release.
// RULE_04: Presence pulse lasts 60 to 240 us; a low in that window means present.
// RULE_05: A zero bit holds the line low 100 us, within 60 to 120 us.
// RULE_06: A write-zero slot lasts 117 us, at least its low time, at most 120.
// RULE_07: Write-one and read slots start with a 5 us low, within 1 to 15 us.
// RULE_08: Write-one and read slots last 117 us, within 60 to 120 us.
// RULE_09: Slave releases a read slot 15 to 45 us after the slot starts.
// RULE_10: One read sample per slot, after the low, before 15 us; low is zero.
// RULE_11: Line released between slots; presence seen is reported upward.
module sw_master
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            reset,
    // Command port
    input  wire logic            cmd_valid,
    input  wire sw_pkg::sw_op_t  cmd_op,
    output logic                 cmd_ready,
    // Result port
    output logic                 res_valid,
    input  wire logic            res_ready,
    output sw_pkg::sw_res_t      res_data,
    // Status
    output logic                 busy,
    output logic                 presence,
    // Open-drain bus line
    input  wire logic            line_in,
    output logic                 line_out,
    output logic                 line_oe
);

    sw_pkg::sw_state_t              state_r;
    sw_pkg::sw_op_t                 op_r;
    logic [sw_pkg::TICK_W-1:0]      tick_r;
    logic [sw_pkg::US_W-1:0]        us_r;
    logic                           tick_last;
    logic                           cmd_ready_r;
    logic                           busy_r;
    logic                           line_oe_r;
    logic                           line_out_r;
    logic                           presence_r;
    logic                           pres_seen_r;
    logic                           read_bit_r;
    logic                           sample_r;
    logic                           push_r;
    sw_pkg::sw_res_t                push_data_r;
    logic                           buf_in_ready;
    logic                           accept;
    logic [sw_pkg::US_W-1:0]        low_end_us;

    assign tick_last  = (tick_r == sw_pkg::TICK_W'(sw_pkg::TICK_CYC - 1));
    assign accept     = cmd_valid && cmd_ready_r;
    assign cmd_ready  = cmd_ready_r;
    assign busy       = busy_r;
    assign presence   = presence_r;
    assign line_oe    = line_oe_r;
    assign line_out   = line_out_r;
    assign low_end_us = (op_r == sw_pkg::SW_OP_WRITE0)
                      ? sw_pkg::US_W'(sw_pkg::T_WR0_US - 1)
                      : sw_pkg::US_W'(sw_pkg::T_LOW1_US - 1);

    // Microsecond timebase, restarted at command accept and at the end of the reset low so phase edges are exact
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tick_r <= '0;
            us_r   <= '0;
        end
        else if (accept || (state_r == sw_pkg::SW_ST_RST_LOW && tick_last
                 && us_r == sw_pkg::US_W'(sw_pkg::T_RSTL_US - 1)))
        begin
            tick_r <= '0;
            us_r   <= '0;
        end
        else if (tick_last)
        begin
            tick_r <= '0;
            us_r   <= us_r + sw_pkg::US_W'(1);
        end
        else
        begin
            tick_r <= tick_r + sw_pkg::TICK_W'(1);
        end
    end

    // Sequencer; a command is only taken when the result buffer has room
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_r     <= sw_pkg::SW_ST_IDLE;
            op_r        <= sw_pkg::SW_OP_RESET;
            cmd_ready_r <= 1'b0;
            busy_r      <= 1'b0;
            line_oe_r   <= 1'b0;
        end
        else
        begin
            case (state_r)
                sw_pkg::SW_ST_IDLE:
                begin
                    line_oe_r   <= 1'b0;                              // [RULE_11]
                    cmd_ready_r <= buf_in_ready && !push_r && !accept; // Pending push may fill tail
                    if (accept)
                    begin
                        op_r      <= cmd_op;
                        busy_r    <= 1'b1;
                        line_oe_r <= 1'b1;
                        state_r   <= (cmd_op == sw_pkg::SW_OP_RESET)
                                   ? sw_pkg::SW_ST_RST_LOW : sw_pkg::SW_ST_SLOT_LOW;
                    end
                end
                sw_pkg::SW_ST_RST_LOW:
                begin
                    if (tick_last && us_r == sw_pkg::US_W'(sw_pkg::T_RSTL_US - 1))
                    begin
                        line_oe_r <= 1'b0;                            // [RULE_01]
                        state_r   <= sw_pkg::SW_ST_RST_HIGH;
                    end
                end
                sw_pkg::SW_ST_RST_HIGH:
                begin
                    if (tick_last && us_r == sw_pkg::US_W'(sw_pkg::T_RSTH_US - 1))
                    begin
                        busy_r  <= 1'b0;                              // [RULE_02]
                        state_r <= sw_pkg::SW_ST_IDLE;
                    end
                end
                sw_pkg::SW_ST_SLOT_LOW:
                begin
                    if (tick_last && us_r == low_end_us)
                    begin
                        line_oe_r <= 1'b0;                            // [RULE_05] [RULE_07]
                        state_r   <= sw_pkg::SW_ST_SLOT_REL;
                    end
                end
                sw_pkg::SW_ST_SLOT_REL:
                begin
                    // Release phase fills the slot, giving the line time to recover
                    if (tick_last && us_r == sw_pkg::US_W'(sw_pkg::T_SLOT_US - 1))
                    begin
                        busy_r  <= 1'b0;                              // [RULE_06] [RULE_08]
                        state_r <= sw_pkg::SW_ST_IDLE;
                    end
                end
                default:
                begin
                    line_oe_r <= 1'b0;
                    busy_r    <= 1'b0;
                    state_r   <= sw_pkg::SW_ST_IDLE;
                end
            endcase
        end
    end

    // Line is only ever pulled low; the pull-up gives the high level
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            line_out_r <= 1'b0;
        else
            line_out_r <= 1'b0;
    end

    // Presence window covers every legal late start of the shortest pulse
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            pres_seen_r <= 1'b0;
        else if (state_r == sw_pkg::SW_ST_RST_LOW)
            pres_seen_r <= 1'b0;
        else if (state_r == sw_pkg::SW_ST_RST_HIGH && !line_in             // [RULE_03]
                 && us_r >= sw_pkg::US_W'(sw_pkg::T_PDH_MIN_US)
                 && us_r <  sw_pkg::US_W'(sw_pkg::T_PRES_END_US))
            pres_seen_r <= 1'b1;                                       // [RULE_04]
    end

    // One read sample, well before the slave may let go of a zero
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sample_r   <= 1'b0;
            read_bit_r <= 1'b0;
        end
        else
        begin
            sample_r <= state_r == sw_pkg::SW_ST_SLOT_REL && op_r == sw_pkg::SW_OP_READ
                     && tick_last && us_r == sw_pkg::US_W'(sw_pkg::T_RD_SMP_US - 1);
            if (state_r == sw_pkg::SW_ST_SLOT_REL && op_r == sw_pkg::SW_OP_READ
                && tick_last && us_r == sw_pkg::US_W'(sw_pkg::T_RD_SMP_US - 1))
                read_bit_r <= line_in;                                 // [RULE_10] [RULE_09]
        end
    end

    // Result words at the end of a reset or right after the read sample; room was checked at accept
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            push_r      <= 1'b0;
            push_data_r <= '0;
            presence_r  <= 1'b0;
        end
        else
        begin
            push_r <= 1'b0;
            if (state_r == sw_pkg::SW_ST_RST_HIGH && tick_last
                && us_r == sw_pkg::US_W'(sw_pkg::T_RSTH_US - 1))
            begin
                push_r      <= 1'b1;
                push_data_r <= '{is_presence: 1'b1, value: pres_seen_r};
                presence_r  <= pres_seen_r;                            // [RULE_11]
            end
            else if (sample_r)
            begin
                push_r      <= 1'b1;
                push_data_r <= '{is_presence: 1'b0, value: read_bit_r};
            end
        end
    end

    sw_res_buf u_buf
    (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (push_r),
        .in_ready  (buf_in_ready),
        .in_data   (push_data_r),
        .out_valid (res_valid),
        .out_ready (res_ready),
        .out_data  (res_data)
    );

    // Helper counters: cycles of the current low and of the current release/slot
    int unsigned low_len_r;
    int unsigned rel_len_r;
    int unsigned slot_len_r;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            low_len_r  <= 0;
            rel_len_r  <= 0;
            slot_len_r <= 0;
        end
        else
        begin
            low_len_r  <= line_oe_r ? low_len_r + 1 : 0;
            rel_len_r  <= line_oe_r ? 0 : rel_len_r + 1;
            slot_len_r <= (state_r == sw_pkg::SW_ST_SLOT_LOW
                          || state_r == sw_pkg::SW_ST_SLOT_REL) ? slot_len_r + 1 : 0;
        end
    end

    sequence s_low_ends;
        $fell(line_oe_r);
    endsequence

    sequence s_slot_ends;
        $fell(state_r == sw_pkg::SW_ST_SLOT_REL);
    endsequence

    chk_reset_low_len : assert property (@(posedge clk) disable iff (reset) // [RULE_01]
        s_low_ends and $past(state_r) == sw_pkg::SW_ST_RST_LOW
        |-> low_len_r >= sw_pkg::C_RSTL_MIN)
        else $error("reset low too short");

    chk_reset_high_len : assert property (@(posedge clk) disable iff (reset) // [RULE_02]
        $fell(state_r == sw_pkg::SW_ST_RST_HIGH) |-> rel_len_r >= sw_pkg::C_RSTH_MIN)
        else $error("reset recovery too short");

    chk_zero_low_len : assert property (@(posedge clk) disable iff (reset) // [RULE_05]
        s_low_ends and op_r == sw_pkg::SW_OP_WRITE0 and $past(state_r) == sw_pkg::SW_ST_SLOT_LOW
        |-> low_len_r >= sw_pkg::C_WR0_MIN && low_len_r <= sw_pkg::C_WR0_MAX)
        else $error("write-zero low out of range");

    chk_short_low_len : assert property (@(posedge clk) disable iff (reset) // [RULE_07]
        s_low_ends and op_r != sw_pkg::SW_OP_WRITE0 and $past(state_r) == sw_pkg::SW_ST_SLOT_LOW
        |-> low_len_r >= sw_pkg::C_LOW1_MIN && low_len_r <= sw_pkg::C_LOW1_MAX)
        else $error("short low out of range");

    chk_slot_length : assert property (@(posedge clk) disable iff (reset) // [RULE_06] [RULE_08]
        s_slot_ends |-> slot_len_r >= sw_pkg::C_SLOT_MIN && slot_len_r <= sw_pkg::C_SLOT_MAX)
        else $error("slot length out of range");

    chk_read_sample_time : assert property (@(posedge clk) disable iff (reset) // [RULE_10]
        sample_r |-> !line_oe_r && op_r == sw_pkg::SW_OP_READ
                  && slot_len_r < sw_pkg::C_REL_MIN)
        else $error("read sample outside window");

    chk_read_result : assert property (@(posedge clk) disable iff (reset) // [RULE_10]
        sample_r |=> push_r && !push_data_r.is_presence && push_data_r.value == $past(read_bit_r))
        else $error("read bit not reported");

    chk_presence_report : assert property (@(posedge clk) disable iff (reset) // [RULE_04]
        $fell(state_r == sw_pkg::SW_ST_RST_HIGH)
        |-> push_r && push_data_r.is_presence && presence_r == $past(pres_seen_r))
        else $error("presence not reported");

    chk_idle_release : assert property (@(posedge clk) disable iff (reset) // [RULE_11]
        state_r == sw_pkg::SW_ST_IDLE && !$past(accept) |-> !line_oe_r && !busy_r)
        else $error("line held between slots");

endmodule : sw_master

// ### sw_pkg.sv
package sw_pkg;

    // Clock rate and the one-microsecond timebase derived from it
    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned TICK_CYC     = CLK_HZ / 1_000_000;
    localparam int unsigned TICK_W       = 7;
    localparam int unsigned US_W         = 10;

    // Line timing, in microseconds
    localparam int unsigned T_RSTL_MIN_US = 480;
    localparam int unsigned T_RSTL_US     = 511;
    localparam int unsigned T_RSTH_MIN_US = 480;
    localparam int unsigned T_RSTH_US     = 512;
    localparam int unsigned T_PDH_MIN_US  = 15;
    localparam int unsigned T_PDH_MAX_US  = 60;
    localparam int unsigned T_PDL_MIN_US  = 60;
    localparam int unsigned T_WR0_MIN_US  = 60;
    localparam int unsigned T_WR0_US      = 100;
    localparam int unsigned T_WR0_MAX_US  = 120;
    localparam int unsigned T_SLOT_MIN_US = 60;
    localparam int unsigned T_SLOT_US     = 117;
    localparam int unsigned T_SLOT_MAX_US = 120;
    localparam int unsigned T_LOW1_MIN_US = 1;
    localparam int unsigned T_LOW1_US     = 5;
    localparam int unsigned T_LOW1_MAX_US = 15;
    localparam int unsigned T_RD_SMP_US   = 13;
    localparam int unsigned T_REL_MIN_US  = 15;

    // Presence is looked for until the shortest pulse starting late must still be low
    localparam int unsigned T_PRES_END_US = T_PDH_MAX_US + T_PDL_MIN_US / 4;

    // Same figures as cycle counts for checking
    localparam int unsigned C_RSTL_MIN   = T_RSTL_MIN_US * TICK_CYC;
    localparam int unsigned C_RSTH_MIN   = T_RSTH_MIN_US * TICK_CYC;
    localparam int unsigned C_WR0_MIN    = T_WR0_MIN_US * TICK_CYC;
    localparam int unsigned C_WR0_MAX    = T_WR0_MAX_US * TICK_CYC;
    localparam int unsigned C_LOW1_MIN   = T_LOW1_MIN_US * TICK_CYC;
    localparam int unsigned C_LOW1_MAX   = T_LOW1_MAX_US * TICK_CYC;
    localparam int unsigned C_SLOT_MIN   = T_SLOT_MIN_US * TICK_CYC;
    localparam int unsigned C_SLOT_MAX   = T_SLOT_MAX_US * TICK_CYC;
    localparam int unsigned C_REL_MIN    = T_REL_MIN_US * TICK_CYC;

    // Commands from the controlling logic
    typedef enum logic [1:0] {
        SW_OP_RESET  = 2'h0,
        SW_OP_WRITE0 = 2'h1,
        SW_OP_WRITE1 = 2'h2,
        SW_OP_READ   = 2'h3
    } sw_op_t;

    // Sequencer states
    typedef enum logic [4:0] {
        SW_ST_IDLE     = 5'h01,
        SW_ST_RST_LOW  = 5'h02,
        SW_ST_RST_HIGH = 5'h04,
        SW_ST_SLOT_LOW = 5'h08,
        SW_ST_SLOT_REL = 5'h10
    } sw_state_t;

    // One result word: presence flag of a reset, or a bit read
    typedef struct packed {
        logic is_presence;
        logic value;
    } sw_res_t;

endpackage : sw_pkg

// ### sw_res_buf.sv
`timescale 1ns/10ps

// Two-entry buffer; head entry drives the outputs straight from flops
module sw_res_buf
(
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           reset,
    // Filling side
    input  wire logic           in_valid,
    output logic                in_ready,
    input  wire sw_pkg::sw_res_t in_data,
    // Draining side
    output logic                out_valid,
    input  wire logic           out_ready,
    output sw_pkg::sw_res_t     out_data
);

    logic            head_valid_r;
    logic            tail_valid_r;
    sw_pkg::sw_res_t head_data_r;
    sw_pkg::sw_res_t tail_data_r;
    logic            push;
    logic            pop;

    // Ready only while the tail slot is free, so a stalled reader loses nothing
    assign in_ready  = !tail_valid_r;
    assign out_valid = head_valid_r;
    assign out_data  = head_data_r;
    assign push      = in_valid && !tail_valid_r;
    assign pop       = head_valid_r && out_ready;

    // Entry movement
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            head_valid_r <= 1'b0;
            tail_valid_r <= 1'b0;
            head_data_r  <= '0;
            tail_data_r  <= '0;
        end
        else if (!head_valid_r || pop)
        begin
            if (tail_valid_r)
            begin
                head_data_r  <= tail_data_r;
                head_valid_r <= 1'b1;
                tail_valid_r <= 1'b0;
            end
            else
            begin
                head_data_r  <= in_data;
                head_valid_r <= push;
            end
        end
        else if (push)
        begin
            tail_data_r  <= in_data;
            tail_valid_r <= 1'b1;
        end
    end

    chk_buf_full_head : assert property (@(posedge clk) disable iff (reset)
        !in_ready |-> out_valid)
        else $error("buffer tail used while head empty");

    chk_buf_stall_hold : assert property (@(posedge clk) disable iff (reset)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("stalled head word changed");

endmodule : sw_res_buf

// ### sw_slave_model.sv
`timescale 1ns/10ps

// Behavioural slave on the shared line; it only pulls low, the pull-up does the rest
module sw_slave_model
(
    // Resolved bus level
    line,
    // Scenario controls
    present,
    rd_bit,
    // High while the slave pulls the line low
    pull
);
    input  wire logic line;
    input  wire logic present;
    input  wire logic rd_bit;
    output logic      pull;

    realtime t0;

    // Every falling edge opens a slot; a low held long past 400 us was a reset
    initial
    begin
        pull = 1'b0;
        forever
        begin
            @(negedge line);
            t0 = $realtime;
            pull = ~rd_bit;
            #30000 pull = 1'b0;
            // Let the resolved line settle before deciding whether the master still holds it
            #1;
            if (line === 1'b0)
            begin
                @(posedge line);
                if (($realtime - t0) > 400000.0 && present === 1'b1)
                begin
                    #30000 pull = 1'b1;
                    #100000 pull = 1'b0;
                end
            end
        end
    end
endmodule : sw_slave_model

// ### tb_top.sv
`timescale 1ns/10ps

module tb_top;
    // Design ports
    logic            clk;
    logic            reset;
    logic            cmd_valid;
    sw_pkg::sw_op_t  cmd_op;
    logic            cmd_ready;
    logic            res_valid;
    logic            res_ready;
    sw_pkg::sw_res_t res_data;
    logic            busy;
    logic            presence;
    logic            line_out;
    logic            line_oe;
    // Shared line and slave controls
    logic            line_lvl;
    logic            slave_pull;
    logic            slave_present;
    logic            slave_bit;
    // Scoreboard and slot measurements
    int              errors;
    int              comparisons;
    int              low_cyc;
    int              busy_cyc;
    int              rel_cyc;

    // Open drain: the line is high unless someone pulls it low
    assign line_lvl = ~line_oe & ~slave_pull;

    sw_master uut
    (
        .clk       (clk),
        .reset     (reset),
        .cmd_valid (cmd_valid),
        .cmd_op    (cmd_op),
        .cmd_ready (cmd_ready),
        .res_valid (res_valid),
        .res_ready (res_ready),
        .res_data  (res_data),
        .busy      (busy),
        .presence  (presence),
        .line_in   (line_lvl),
        .line_out  (line_out),
        .line_oe   (line_oe)
    );

    sw_slave_model slave
    (
        .line    (line_lvl),
        .present (slave_present),
        .rd_bit  (slave_bit),
        .pull    (slave_pull)
    );

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim();
        $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    // Inputs move 1 ns after the edge so outputs are settled when looked at
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic check_eq(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check_eq

    task automatic check_rng(input string name, input int val, input int lo, input int hi);
        comparisons++;
        if (val < lo || val > hi)
        begin
            errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, val);
        end
    endtask : check_rng

    // A bound that runs out is a mismatch and ends the run at once
    task automatic timed_out(input string name);
        errors++;
        $display("[ERR] %s expected done seen timeout", name);
        end_sim();
    endtask : timed_out

    // Issue one command, then time the low and released parts of the slot
    task automatic send_cmd(input sw_pkg::sw_op_t op);
        int i;
        for (i = 0; i < 200 && cmd_ready !== 1'b1; i++)
            tick();
        if (i == 200)
        begin
            timed_out("cmd_ready");
        end
        cmd_op = op;
        cmd_valid = 1'b1;
        tick();
        cmd_valid = 1'b0;
        low_cyc = 0;
        busy_cyc = 0;
        rel_cyc = 0;
        for (i = 0; i < 110000 && busy === 1'b1; i++)
        begin
            busy_cyc++;
            if (line_oe === 1'b1)
                low_cyc++;
            else
                rel_cyc++;
            tick();
        end
        if (i == 110000)
        begin
            timed_out("busy");
        end
        check_eq("line_oe between slots", line_oe, 1'b0);
        check_eq("line_out", line_out, 1'b0);
    endtask : send_cmd

    // Take the head result word and compare it
    task automatic get_res(input logic [1:0] exp);
        int i;
        for (i = 0; i < 200 && res_valid !== 1'b1; i++)
            tick();
        if (i == 200)
        begin
            timed_out("res_valid");
        end
        check_eq("res_data", res_data, exp);
        res_ready = 1'b1;
        tick();
        res_ready = 1'b0;
        // One idle edge so a following take does not re-raise ready in the same step
        tick();
    endtask : get_res

    task automatic test_reset_values();
        check_eq("cmd_ready in reset", cmd_ready, 1'b0);
        check_eq("busy in reset", busy, 1'b0);
        check_eq("presence in reset", presence, 1'b0);
        check_eq("line_oe in reset", line_oe, 1'b0);
        $display("test_reset_values done");
    endtask : test_reset_values

    task automatic test_reset_presence();
        slave_present = 1'b1;
        send_cmd(sw_pkg::SW_OP_RESET);
        check_rng("reset low", low_cyc, sw_pkg::C_RSTL_MIN, 51102);
        check_rng("reset high", rel_cyc, sw_pkg::C_RSTH_MIN, 51202);
        get_res(2'b11);
        check_eq("presence", presence, 1'b1);
        $display("test_reset_presence done");
    endtask : test_reset_presence

    task automatic test_write0();
        send_cmd(sw_pkg::SW_OP_WRITE0);
        check_rng("write0 low", low_cyc, sw_pkg::C_WR0_MIN, sw_pkg::C_WR0_MAX);
        check_rng("write0 slot", busy_cyc, low_cyc, sw_pkg::C_SLOT_MAX);
        check_eq("no write result", res_valid, 1'b0);
        $display("test_write0 done");
    endtask : test_write0

    task automatic test_write1();
        send_cmd(sw_pkg::SW_OP_WRITE1);
        check_rng("write1 low", low_cyc, sw_pkg::C_LOW1_MIN, sw_pkg::C_LOW1_MAX);
        check_rng("write1 slot", busy_cyc, sw_pkg::C_SLOT_MIN, sw_pkg::C_SLOT_MAX);
        check_eq("no write result", res_valid, 1'b0);
        $display("test_write1 done");
    endtask : test_write1

    // Two reads left unread fill the buffer; a third command must wait
    task automatic test_read_buffer();
        slave_bit = 1'b0;
        send_cmd(sw_pkg::SW_OP_READ);
        check_rng("read low", low_cyc, sw_pkg::C_LOW1_MIN, sw_pkg::C_LOW1_MAX);
        check_rng("read slot", busy_cyc, sw_pkg::C_SLOT_MIN, sw_pkg::C_SLOT_MAX);
        slave_bit = 1'b1;
        send_cmd(sw_pkg::SW_OP_READ);
        cmd_op = sw_pkg::SW_OP_WRITE1;
        cmd_valid = 1'b1;
        repeat (20) tick();
        check_eq("cmd_ready buffer full", cmd_ready, 1'b0);
        check_eq("busy buffer full", busy, 1'b0);
        cmd_valid = 1'b0;
        get_res(2'b00);
        get_res(2'b01);
        check_eq("res_valid drained", res_valid, 1'b0);
        $display("test_read_buffer done");
    endtask : test_read_buffer

    // Main sequence
    initial
    begin
        errors = 0;
        comparisons = 0;
        reset = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = sw_pkg::SW_OP_RESET;
        res_ready = 1'b0;
        slave_present = 1'b0;
        slave_bit = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        test_reset_values();
        reset = 1'b0;
        test_reset_presence();
        test_write0();
        test_write1();
        test_read_buffer();
        end_sim();
    end
endmodule : tb_top
